// *** common/snp_pkg.sv ***
// What this block does
// - Delimiter process ignored when delimiter disabled
// - Do nothing: pack including delimiter bytes
// - Plus one: pack after one more byte
// - Plus two: pack after two more bytes
// - Strip: pack and drop delimiter bytes
// - Force time zero never flushes buffer
// - Idle gap of force time flushes buffer
// - Periodic keep-alive probes are sent
// - Keep-alive timeout zero keeps connection open
// - Unanswered keep-alive past timeout closes connection
// - Inactivity zero never closes connection
// - No traffic for inactivity time closes
// - Settings apply only in client mode
// - Delimiters end packet, one or two bytes
// - Nonzero length limit sends at that count
package snp_pkg;
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
	localparam int unsigned MS_PER_MIN    = 60000;
	localparam int unsigned KA_PERIOD_MIN = 1;
	localparam int unsigned FIFO_DEPTH    = 16;
	localparam int unsigned PKT_MAX       = 1024;
	localparam logic [3:0]  A_CTRL        = 4'h0;
	localparam logic [3:0]  A_DELIM       = 4'h1;
	localparam logic [3:0]  A_PKTLEN      = 4'h2;
	localparam logic [3:0]  A_FORCE       = 4'h3;
	localparam logic [3:0]  A_INACT       = 4'h4;
	localparam logic [3:0]  A_ALIVE       = 4'h5;
	localparam logic [3:0]  A_STATUS      = 4'h6;
	localparam int unsigned C_CLIENT      = 0;
	localparam int unsigned C_D1EN        = 1;
	localparam int unsigned C_D2EN        = 2;
	localparam int unsigned C_PROC_LO     = 3;
	localparam logic [6:0]  ALIVE_RST     = 7'h07;
	typedef enum logic [1:0] {
		SNP_NOTHING = 2'b00,
		SNP_PLUS1   = 2'b01,
		SNP_PLUS2   = 2'b10,
		SNP_STRIP   = 2'b11
	} snp_proc_t;
endpackage

// *** src/snp_fifo.sv ***
`timescale 1ns/1ns
module snp_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic [W-1:0] in_data_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	output logic [W-1:0]      out_data_out,
	output logic              out_valid_out,
	input  wire logic         out_ready_in
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;
	logic         full;
	logic         empty;
	assign empty = wp_q == rp_q;
	assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign in_ready_out = !full;
	assign out_valid_out = !empty;
	assign out_data_out = mem[rp_q[AW-1:0]];
	always_ff @(posedge clk_in) begin
		if (in_valid_in && !full) begin
			mem[wp_q[AW-1:0]] <= in_data_in;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (in_valid_in && !full) begin
				wp_q <= wp_q + 1'b1;
			end
			if (out_ready_in && !empty) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule

// *** src/snp_packer.sv ***
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module snp_packer
	import snp_pkg::*;
#(
	parameter int unsigned CYC_MS = CYC_PER_MS,
	parameter int unsigned MS_MIN = MS_PER_MIN,
	parameter int unsigned KA_PER = KA_PERIOD_MIN
) (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [15:0]     rdata_out,
	input  wire logic [7:0] ser_data_in,
	input  wire logic       ser_valid_in,
	output logic            ser_ready_out,
	input  wire logic       net_rx_in,
	input  wire logic       conn_open_in,
	input  wire logic       ka_reply_in,
	output logic [7:0]      net_data_out,
	output logic            net_valid_out,
	output logic            net_last_out,
	input  wire logic       net_ready_in,
	output logic            ka_send_out,
	output logic            conn_close_out
);
	// ========================================
	// Configuration registers
	logic [5:0]  ctrl_q;
	logic [15:0] delim_q;
	logic [10:0] pktlen_q;
	logic [15:0] force_q;
	logic [15:0] inact_q;
	logic [6:0]  alive_q;
	logic        client;
	logic        d1en;
	logic        d2en;
	snp_proc_t   proc;
	assign client = ctrl_q[C_CLIENT];
	assign d1en = client && ctrl_q[C_D1EN];
	assign d2en = d1en && ctrl_q[C_D2EN];
	assign proc = d1en ? snp_proc_t'(ctrl_q[C_PROC_LO+:2]) : SNP_NOTHING;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_q   <= '0;
			delim_q  <= '0;
			pktlen_q <= '0;
			force_q  <= '0;
			inact_q  <= '0;
			alive_q  <= ALIVE_RST;
		end else if (wr_in) begin
			case (addr_in)
				A_CTRL:   ctrl_q <= wdata_in[5:0];
				A_DELIM:  delim_q <= wdata_in;
				A_PKTLEN: pktlen_q <= (wdata_in > 16'(PKT_MAX)) ? 11'(PKT_MAX) : wdata_in[10:0];
				A_FORCE:  force_q <= wdata_in;
				A_INACT:  inact_q <= wdata_in;
				A_ALIVE:  alive_q <= wdata_in[6:0];
				default:  ;
			endcase
		end
	end
	// ========================================
	// Serial intake and delimiter handling
	logic        in_ready;
	logic        take;
	logic [7:0]  prev_q;
	logic        prev_ok_q;
	logic [1:0]  tail_q;
	logic        tail_act_q;
	logic [10:0] cnt_q;
	logic        hit;
	logic        flush_req;
	logic        last_tag;
	logic        keep;
	logic        fire;
	logic        idle_flush;
	logic [7:0]  held_q;
	logic        held_ok_q;
	assign take = ser_valid_in && ser_ready_out;
	assign hit = d1en && (d2en ? (prev_ok_q && prev_q == delim_q[7:0] && ser_data_in == delim_q[15:8])
		: ser_data_in == delim_q[7:0]);
	always_comb begin
		keep = 1'b1;
		last_tag = 1'b0;
		fire = 1'b0;
		if (tail_act_q) begin
			fire = tail_q == 2'd1;
		end else if (hit) begin
			case (proc)
				SNP_NOTHING: fire = 1'b1;
				SNP_STRIP: begin
					fire = 1'b1;
					keep = 1'b0;
				end
				default: fire = 1'b0;
			endcase
		end else if (d2en && prev_ok_q && prev_q == delim_q[7:0] && proc == SNP_STRIP) begin
			keep = 1'b1;
		end
		if (pktlen_q != '0 && client && cnt_q + 11'd1 >= pktlen_q) begin
			fire = 1'b1;
		end
		last_tag = fire;
	end
	// Strip of a two-byte delimiter: first byte is held back one slot until the second decides.
	logic        emit_v;
	logic [8:0]  emit_w;
	logic        strip2;
	assign strip2 = d2en && proc == SNP_STRIP;
	always_comb begin
		emit_v = 1'b0;
		emit_w = '0;
		if (take) begin
			if (strip2) begin
				emit_v = held_ok_q && !hit;
				emit_w = {last_tag, held_q};
				if (hit && held_ok_q) begin
					emit_v = 1'b0;
				end
			end else begin
				emit_v = keep;
				emit_w = {last_tag, ser_data_in};
				if (!keep && cnt_q == '0) begin
					emit_v = 1'b0;
				end
			end
		end else if (idle_flush) begin
			emit_v = strip2 && held_ok_q;
			emit_w = {1'b1, held_q};
		end
	end
	// ========================================
	// Packet boundary bookkeeping
	logic pend_last_q;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			prev_q      <= '0;
			prev_ok_q   <= 1'b0;
			tail_q      <= '0;
			tail_act_q  <= 1'b0;
			cnt_q       <= '0;
			held_q      <= '0;
			held_ok_q   <= 1'b0;
			pend_last_q <= 1'b0;
		end else begin
			if (take) begin
				prev_q    <= ser_data_in;
				prev_ok_q <= !fire;
				held_q    <= ser_data_in;
				held_ok_q <= strip2 && !hit && !fire;
				cnt_q     <= fire ? '0 : cnt_q + 11'd1;
				if (tail_act_q) begin
					tail_q     <= tail_q - 2'd1;
					tail_act_q <= tail_q != 2'd1;
				end else if (hit && (proc == SNP_PLUS1 || proc == SNP_PLUS2)) begin
					tail_q     <= (proc == SNP_PLUS1) ? 2'd1 : 2'd2;
					tail_act_q <= 1'b1;
				end
				pend_last_q <= !emit_v && fire && cnt_q != '0;
			end else if (idle_flush) begin
				cnt_q       <= '0;
				prev_ok_q   <= 1'b0;
				tail_act_q  <= 1'b0;
				held_ok_q   <= 1'b0;
				pend_last_q <= !(strip2 && held_ok_q);
			end else if (pend_last_q && in_ready) begin
				pend_last_q <= 1'b0;
			end
		end
	end
	// A boundary with no byte to carry it goes out as a lone marker word with data zero.
	logic       fin_v;
	logic [8:0] fin_w;
	assign fin_v = emit_v || (pend_last_q && !take);
	assign fin_w = emit_v ? emit_w : {1'b1, 8'h00};
	assign ser_ready_out = in_ready && !pend_last_q;
	snp_fifo #(.W(9), .D(FIFO_DEPTH)) u_fifo (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.in_data_in    (fin_w),
		.in_valid_in   (fin_v),
		.in_ready_out  (in_ready),
		.out_data_out  ({net_last_out, net_data_out}),
		.out_valid_out (net_valid_out),
		.out_ready_in  (net_ready_in)
	);
	// ========================================
	// Millisecond tick and timers
	logic [$clog2(CYC_MS)-1:0] pre_q;
	logic                      tick;
	logic [15:0]               gap_q;
	logic [15:0]               idle_q;
	logic [31:0]               ka_q;
	logic [31:0]               kper_q;
	logic                      ka_wait_q;
	logic                      close_q;
	logic                      ka_q_pulse;
	assign tick = pre_q == ($clog2(CYC_MS))'(CYC_MS - 1);
	assign idle_flush = client && force_q != '0 && tick && gap_q + 16'd1 >= force_q
		&& cnt_q != '0 && !take;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pre_q <= '0;
		end else begin
			pre_q <= tick ? '0 : pre_q + 1'b1;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			gap_q <= '0;
		end else if (take || idle_flush || cnt_q == '0) begin
			gap_q <= '0;
		end else if (tick && gap_q != 16'hFFFF) begin
			gap_q <= gap_q + 16'd1;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			idle_q <= '0;
		end else if (take || net_rx_in || !conn_open_in) begin
			idle_q <= '0;
		end else if (tick && idle_q != 16'hFFFF) begin
			idle_q <= idle_q + 16'd1;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ka_q       <= '0;
			kper_q     <= '0;
			ka_wait_q  <= 1'b0;
			ka_q_pulse <= 1'b0;
		end else begin
			ka_q_pulse <= 1'b0;
			if (!conn_open_in || !client) begin
				kper_q    <= '0;
				ka_q      <= '0;
				ka_wait_q <= 1'b0;
			end else begin
				// Cleared first so a probe issued in the same cycle still wins
				if (ka_reply_in) begin
					ka_wait_q <= 1'b0;
				end
				if (tick) begin
					kper_q <= (kper_q + 32'd1 >= KA_PER * MS_MIN) ? '0 : kper_q + 32'd1;
					if (kper_q + 32'd1 >= KA_PER * MS_MIN && !ka_wait_q) begin
						ka_q_pulse <= 1'b1;
						ka_wait_q  <= 1'b1;
						ka_q       <= '0;
					end else if (ka_wait_q) begin
						ka_q <= ka_q + 32'd1;
					end
				end
			end
		end
	end
	assign ka_send_out = ka_q_pulse;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			close_q <= 1'b0;
		end else begin
			close_q <= client && conn_open_in && (
				(inact_q != '0 && idle_q >= inact_q) ||
				(alive_q != '0 && ka_wait_q && !ka_reply_in
					&& ka_q >= 32'(alive_q) * MS_MIN));
		end
	end
	assign conn_close_out = close_q;
	// ========================================
	// Read port
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= '0;
		end else if (rd_in) begin
			case (addr_in)
				A_CTRL:   rdata_out <= {10'h000, ctrl_q};
				A_DELIM:  rdata_out <= delim_q;
				A_PKTLEN: rdata_out <= {5'h00, pktlen_q};
				A_FORCE:  rdata_out <= force_q;
				A_INACT:  rdata_out <= inact_q;
				A_ALIVE:  rdata_out <= {9'h000, alive_q};
				A_STATUS: rdata_out <= {ka_wait_q, close_q, 3'h0, cnt_q};
				default:  rdata_out <= '0;
			endcase
		end else begin
			rdata_out <= '0;
		end
	end
endmodule

// *** bench/snp_packer_checker.sv ***
`timescale 1ns/1ns
// =====================
// Port checker
module snp_packer_checker
	import snp_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        reset_in,
	input wire logic [3:0]  addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic [7:0]  ser_data_in,
	input wire logic        ser_valid_in,
	input wire logic        ser_ready_out,
	input wire logic        net_rx_in,
	input wire logic        conn_open_in,
	input wire logic        ka_reply_in,
	input wire logic [7:0]  net_data_out,
	input wire logic        net_valid_out,
	input wire logic        net_last_out,
	input wire logic        net_ready_in,
	input wire logic        ka_send_out,
	input wire logic        conn_close_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	// Shadow of the control word, seen on the register port
	logic [5:0] ctrl_sh_q;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl_sh_q <= '0;
		end else if (wr_in && addr_in == A_CTRL) begin
			ctrl_sh_q <= wdata_in[5:0];
		end
	end

	rd_idle_a: assert property (
		!$past(rd_in) |-> rdata_out == 16'h0000) else $error("read data off slot");
	stat_close_a: assert property (
		rd_in && addr_in == A_STATUS |=> rdata_out[14] == $past(conn_close_out))
		else $error("status close bit wrong");
	// Strip mode may drop or hold a byte back, so only the keeping modes are held to this
	ser_take_a: assert property (
		ser_valid_in && ser_ready_out && ctrl_sh_q[C_PROC_LO+:2] != 2'b11
		|=> ##[0:1] net_valid_out) else $error("byte lost");
	net_hold_a: assert property (
		net_valid_out && !net_ready_in |=> net_valid_out
		&& $stable({net_data_out, net_last_out})) else $error("word not held");
	// A pending marker may need one extra slot once the far side drains
	ready_back_a: assert property (
		!ser_ready_out && net_ready_in ##1 net_ready_in |-> ##[0:1] ser_ready_out)
		else $error("refusal outlives drain");
	// Only words closing a packet may come from a flush without a fresh byte
	net_rise_a: assert property (
		$rose(net_valid_out) && !net_last_out |-> $past(ser_valid_in))
		else $error("word from nowhere");
	ka_gap_a: assert property (
		ka_send_out |=> !ka_send_out [*8]) else $error("probe too soon");
	ka_open_a: assert property (
		ka_send_out |-> $past(conn_open_in)) else $error("probe while closed");

	ka_c: cover property (ka_send_out);
	close_c: cover property ($rose(conn_close_out));
	pkt_c: cover property (net_valid_out && net_ready_in && net_last_out);
	mark_c: cover property (net_valid_out && net_last_out && net_data_out == 8'h00);
endmodule

bind snp_packer snp_packer_checker chk (
	.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
	.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ser_data_in(ser_data_in),
	.ser_valid_in(ser_valid_in), .ser_ready_out(ser_ready_out), .net_rx_in(net_rx_in),
	.conn_open_in(conn_open_in), .ka_reply_in(ka_reply_in), .net_data_out(net_data_out),
	.net_valid_out(net_valid_out), .net_last_out(net_last_out),
	.net_ready_in(net_ready_in), .ka_send_out(ka_send_out),
	.conn_close_out(conn_close_out));

// *** bench/snp_net_peer.sv ***
`timescale 1ns/1ns
// =====================
// Remote host model
module snp_net_peer (
	input  wire logic       clk_in,
	input  wire logic [7:0] data_in,
	input  wire logic       valid_in,
	input  wire logic       last_in,
	input  wire logic       ka_in,
	input  wire logic       stall_in,
	input  wire logic       answer_in,
	output logic            ready_out,
	output logic            reply_out
);
	logic [8:0] got[$];
	// Stall lets the bench back the buffer up to its limit
	assign ready_out = !stall_in;
	initial reply_out = 1'b0;
	always @(posedge clk_in) begin
		if (valid_in === 1'b1 && ready_out)
			got.push_back({last_in, data_in});
		reply_out <= ka_in && answer_in;
	end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
// =====================
// Bench top
module tb_top;
	import snp_pkg::*;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch at %0t got %h exp %h", $time, a, b); end end
	logic        clk_in, reset_in, wr_s, rd_s, sv, sr, nrx, copen, kar, nv, nl, nr, kas, cc;
	logic        stall, answer;
	logic [3:0]  addr;
	logic [7:0]  sd, nd;
	logic [15:0] wdata, rdata, v;
	int          bad_count = 0, tests_run = 0, kas_n = 0;
	logic [8:0]  e[$];
	// A tail byte already queued unmarked is closed by the idle flush's lone marker
	localparam logic [8:0] DX [4][5] = '{'{9'h0A1, 9'h10D, 9'h0B1, 9'h0B2, 9'h100},
		'{9'h0A1, 9'h00D, 9'h1B1, 9'h0B2, 9'h100}, '{9'h0A1, 9'h00D, 9'h0B1, 9'h1B2, 9'h000},
		'{9'h0A1, 9'h100, 9'h0B1, 9'h0B2, 9'h100}};
	localparam int DN [4] = '{5, 5, 4, 5};

	snp_packer #(.CYC_MS(4), .MS_MIN(10), .KA_PER(1)) dut (
		.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
		.rd_in(rd_s), .rdata_out(rdata), .ser_data_in(sd), .ser_valid_in(sv),
		.ser_ready_out(sr), .net_rx_in(nrx), .conn_open_in(copen), .ka_reply_in(kar),
		.net_data_out(nd), .net_valid_out(nv), .net_last_out(nl), .net_ready_in(nr),
		.ka_send_out(kas), .conn_close_out(cc));
	snp_net_peer peer (.clk_in(clk_in), .data_in(nd), .valid_in(nv), .last_in(nl),
		.ka_in(kas), .stall_in(stall), .answer_in(answer), .ready_out(nr), .reply_out(kar));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(negedge clk_in) if (kas === 1'b1) kas_n++;

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic hang();
		bad_count++;
		summarize();
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk_in);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_in);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk_in);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic put(logic [7:0] b);
		int n;
		@(posedge clk_in);
		sd <= b;
		sv <= 1'b1;
		// Ready is judged once settled, before the edge that takes the byte
		@(negedge clk_in);
		for (n = 0; n < 200 && sr !== 1'b1; n++)
			@(negedge clk_in);
		if (n == 200) hang();
		@(posedge clk_in);
		sv <= 1'b0;
	endtask
	task automatic expect_q();
		int n;
		for (n = 0; n < 400 && peer.got.size() < e.size(); n++)
			@(posedge clk_in);
		if (n == 400) hang();
		tick(20);
		`CHK(peer.got.size(), e.size())
		foreach (e[i])
			`CHK(peer.got[i], e[i])
		peer.got.delete();
	endtask
	task automatic wait_close();
		int n;
		for (n = 0; n < 400 && cc !== 1'b1; n++)
			@(posedge clk_in);
		if (n == 400) hang();
	endtask

	// =====================
	// Scenarios
	task automatic s_regs();
		rd(A_ALIVE, v);
		`CHK(v, {9'h000, ALIVE_RST})
		rd(4'hF, v);
		`CHK(v, 16'h0000)
		wr(A_DELIM, 16'h0D0D);
		rd(A_DELIM, v);
		`CHK(v, 16'h0D0D)
	endtask
	task automatic s_delim();
		wr(A_FORCE, 16'h0003);
		wr(A_DELIM, 16'h000D);
		for (int k = 0; k < 4; k++) begin
			wr(A_CTRL, 16'h0003 | 16'(k << C_PROC_LO));
			put(8'hA1);
			put(8'h0D);
			put(8'hB1);
			put(8'hB2);
			e = {};
			for (int j = 0; j < DN[k]; j++)
				e.push_back(DX[k][j]);
			expect_q();
		end
		wr(A_CTRL, 16'h0019);
		put(8'hA1);
		put(8'h0D);
		e = '{9'h0A1, 9'h00D, 9'h100};
		expect_q();
		wr(A_DELIM, 16'h0A0D);
		wr(A_CTRL, 16'h0007);
		put(8'hA1);
		put(8'h0D);
		put(8'h0A);
		put(8'hB1);
		e = '{9'h0A1, 9'h00D, 9'h10A, 9'h0B1, 9'h100};
		expect_q();
	endtask
	task automatic s_idle();
		wr(A_FORCE, 16'h0000);
		wr(A_CTRL, 16'h0001);
		put(8'h5A);
		tick(60);
		`CHK(peer.got.size(), 1)
		wr(A_FORCE, 16'h0003);
		e = '{9'h05A, 9'h100};
		expect_q();
	endtask
	task automatic s_fill();
		wr(A_FORCE, 16'h0000);
		wr(A_PKTLEN, 16'h0010);
		stall <= 1'b1;
		e = {};
		for (int i = 0; i < 16; i++) begin
			put(8'(i));
			e.push_back({i == 15, 8'(i)});
		end
		@(negedge clk_in);
		`CHK(sr, 1'b0)
		stall <= 1'b0;
		expect_q();
		wr(A_PKTLEN, 16'h0000);
	endtask
	task automatic s_inact();
		wr(A_ALIVE, 16'h0000);
		wr(A_INACT, 16'h0003);
		wait_close();
		`CHK(cc, 1'b1)
		rd(A_STATUS, v);
		`CHK(v[14], 1'b1)
		wr(A_INACT, 16'h0000);
		tick(5);
		`CHK(cc, 1'b0)
		wr(A_INACT, 16'h0003);
		repeat (8) begin
			@(posedge clk_in);
			nrx <= 1'b1;
			@(posedge clk_in);
			nrx <= 1'b0;
			tick(4);
			`CHK(cc, 1'b0)
		end
		wr(A_CTRL, 16'h0000);
		tick(60);
		`CHK(cc, 1'b0)
		wr(A_INACT, 16'h0000);
		wr(A_CTRL, 16'h0001);
	endtask
	task automatic s_alive();
		answer <= 1'b0;
		tick(200);
		`CHK(cc, 1'b0)
		wr(A_ALIVE, 16'h0001);
		wait_close();
		`CHK(cc, 1'b1)
		`CHK(kas_n != 0, 1'b1)
	endtask

	initial begin
		{reset_in, copen, answer} = 3'b111;
		{wr_s, rd_s, sv, nrx, stall, addr, wdata, sd} = '0;
		tick(6);
		reset_in <= 1'b0;
		s_regs();
		s_delim();
		s_idle();
		s_fill();
		s_inact();
		s_alive();
		summarize();
	end
endmodule
